// >>> ecj_err_chan.sv
// One channel of error accumulation with snapshot at each round end.
// Assumes error pulses come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ecj_err_chan (
  input wire logic clock,
  input wire logic rst,
  input wire logic err_pulse,
  input wire logic round_end,
  output logic [15:0] snap,
  output logic ovf_pulse
);

  logic [15:0] acc_q;
  logic [15:0] snap_q;
  logic ovf_q;

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator, restarted at each round end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= 16'h0000;
    end else if (round_end) begin
      acc_q <= {15'h0000, err_pulse};
    end else if (err_pulse) begin
      acc_q <= acc_q + 16'h0001;
    end
  end

  // Snapshot overwritten each round [R05] [R04]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      snap_q <= ecj_pkg::ERR_SNAP_RESET; // [R03]
    end else if (round_end) begin
      snap_q <= acc_q;
    end
  end

  // Wrap of the 16-bit count [R15]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= err_pulse && !round_end && (acc_q == 16'hFFFF);
    end
  end

  assign snap = snap_q;
  assign ovf_pulse = ovf_q;

endmodule
`default_nettype wire

// >>> ecj_jit_peak.sv
// Running positive and negative jitter peaks, loaded at each round end.
// Assumes demodulated samples arrive on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ecj_jit_peak (
  input wire logic clock,
  input wire logic rst,
  input wire ecj_pkg::ecj_jit_smp_t smp,
  input wire logic round_end,
  output logic [11:0] pos_peak,
  output logic [11:0] neg_peak
);

  logic [11:0] pos_run_q;
  logic [11:0] neg_run_q;
  logic [11:0] pos_q;
  logic [11:0] neg_q;

  //////////////////////////////////////////////////////////////////////////////
  // Running maxima for the current round
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_run_q <= ecj_pkg::PEAK_RESET;
      neg_run_q <= ecj_pkg::PEAK_RESET;
    end else if (round_end) begin
      pos_run_q <= smp.valid ? smp.pos : ecj_pkg::PEAK_RESET;
      neg_run_q <= smp.valid ? smp.neg : ecj_pkg::PEAK_RESET;
    end else if (smp.valid) begin
      if (smp.pos > pos_run_q) begin
        pos_run_q <= smp.pos;
      end
      if (smp.neg > neg_run_q) begin
        neg_run_q <= smp.neg;
      end
    end
  end

  // Results overwritten each round [R14] [R07]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= ecj_pkg::PEAK_RESET;
      neg_q <= ecj_pkg::PEAK_RESET;
    end else if (round_end) begin
      pos_q <= pos_run_q;
      neg_q <= neg_run_q;
    end
  end

  assign pos_peak = pos_q;
  assign neg_peak = neg_q;

endmodule
`default_nettype wire

// >>> ecj_pkg.sv
// Constants and carrier types for the error count and jitter readout block.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
package ecj_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned PEAK_W = 12;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_ERR_LOW_CH1 = 12'h023;
  localparam logic [11:0] IDX_ERR_HIGH_CH1 = 12'h024;
  localparam logic [11:0] IDX_CH_STRIDE = 12'h040;
  localparam logic [11:0] IDX_CH_LIMIT = 12'h3C0;
  localparam logic [11:0] IDX_ERR_LOW_CH0 = 12'h7E3;
  localparam logic [11:0] IDX_ERR_HIGH_CH0 = 12'h7E4;
  localparam logic [11:0] IDX_JIT_CFG = 12'h7E5;
  localparam logic [11:0] IDX_JIT_POS_LOW = 12'h7E6;
  localparam logic [11:0] IDX_JIT_POS_HIGH = 12'h7E7;
  localparam logic [11:0] IDX_JIT_NEG_LOW = 12'h7E8;
  localparam logic [11:0] IDX_JIT_NEG_HIGH = 12'h7E9;
  localparam logic [11:0] IDX_OVF_STATUS = 12'h7F0;
  localparam logic [11:0] IDX_OVF_MASK = 12'h7F1;
  localparam logic [11:0] IDX_ERR_CTRL = 12'h7F2;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned JIT_BW_BIT = 0;
  localparam int unsigned JIT_MODE_BIT = 1;
  localparam int unsigned JIT_STOP_BIT = 2;
  localparam int unsigned ERR_TRIG_BIT = 0;
  localparam int unsigned ERR_MODE_BIT = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] JIT_CFG_RESET = 3'h0;
  localparam logic [1:0] ERR_CTRL_RESET = 2'h0;
  localparam logic [15:0] ERR_SNAP_RESET = 16'h0000;
  localparam logic [11:0] PEAK_RESET = 12'h000;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Timing: automatic round of one second
  localparam int unsigned ROUND_PERIOD_MS = 1000;
  localparam int unsigned CLOCK_KHZ = 100000;
  localparam int unsigned ROUND_CYCLES = ROUND_PERIOD_MS * CLOCK_KHZ;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic [11:0] pos;
    logic [11:0] neg;
  } ecj_jit_smp_t;

  typedef struct packed {
    logic e1_mode;
    logic wide_low_corner;
  } ecj_band_t;

endpackage

// >>> ecj_top.sv
// Error count snapshots and channel-0 jitter peak readout on Wishbone.
// Assumes a single 100 MHz clock; all event inputs are on that clock.
//
// Functional notes
// R01 - 16-bit error count read as low byte and high byte registers.
// R02 - Count pair repeats per channel; channel 1 at 023H, channel 0 at 7E3H.
// R03 - Error count snapshots reset to zero and are read-only.
// R04 - Count mode bit 1 picks automatic or manual snapshot refresh.
// R05 - Every counting round overwrites the previous snapshot.
// R06 - Jitter stop bit 2 acts only while period mode is manual.
// R07 - Stop bit rising edge loads positive and negative peak results.
// R08 - Software clears the stop bit before the next round.
// R09 - Period mode bit 1: 0 manual stop, 1 automatic one second.
// R10 - Bandwidth bit 0: 10 Hz-40 KHz T1/J1, 20 Hz-100 KHz E1.
// R11 - Bandwidth bit 1: 8 KHz-40 KHz T1/J1, 18 KHz-100 KHz E1.
// R12 - Positive peak is 12 bits, high then low byte, UIpp times 16; here the low byte is at 7E6H and the high at 7E7H.
// R13 - Jitter is channel 0 only; config at 7E5H, results from 7E6H.
// R14 - Each jitter round overwrites peak results, which reset to zero.
// R15 - Count wrap sets sticky per-channel status, cleared by writing one.
// R16 - Line standard T1/J1 or E1 comes in as an input.
`timescale 1ns/100ps
`default_nettype none
module ecj_top #(
  parameter int unsigned ROUND_CYCLES = ecj_pkg::ROUND_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] err_pulse,
  input wire ecj_pkg::ecj_jit_smp_t jit_smp,
  input wire logic e1_mode,
  output ecj_pkg::ecj_band_t jit_band,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [2:0] jit_cfg_q;
  logic [1:0] err_ctrl_q;
  logic err_trig_q;
  logic stop_prev_q;
  logic [31:0] tmr_q;
  logic tick_q;
  logic [15:0] ovf_sts_q;
  logic [15:0] ovf_mask_q;
  logic [15:0] ovf_pulse;
  logic irq_q;
  ecj_pkg::ecj_band_t band_q;
  logic [15:0] snap [16];
  logic [11:0] pos_peak;
  logic [11:0] neg_peak;
  logic [11:0] idx;
  logic req;
  logic wr;
  logic err_end;
  logic jit_end;
  logic jit_manual;
  logic stop_rise;

  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign jit_manual = !jit_cfg_q[ecj_pkg::JIT_MODE_BIT];
  assign stop_rise = jit_cfg_q[ecj_pkg::JIT_STOP_BIT] && !stop_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Round end selection
  always_comb begin
    if (err_ctrl_q[ecj_pkg::ERR_MODE_BIT]) begin
      err_end = err_trig_q; // [R04]
    end else begin
      err_end = tick_q;
    end
  end

  always_comb begin
    if (jit_manual) begin
      jit_end = stop_rise; // [R06] [R07]
    end else begin
      jit_end = tick_q; // [R09]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One second round timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tmr_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tmr_q == 32'(ROUND_CYCLES - 1)) begin
      tmr_q <= 32'h00000000;
      tick_q <= 1'b1; // [R09]
    end else begin
      tmr_q <= tmr_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels and overflow status
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_ch
      ecj_err_chan u_chan (
        .clock(clock),
        .rst(rst),
        .err_pulse(err_pulse[g]),
        .round_end(err_end),
        .snap(snap[g]),
        .ovf_pulse(ovf_pulse[g])
      );

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          ovf_sts_q[g] <= 1'b0;
        end else if (ovf_pulse[g]) begin
          ovf_sts_q[g] <= 1'b1; // [R15]
        end else if (req && wb_we_i && idx == ecj_pkg::IDX_OVF_STATUS &&
                     wb_sel_i[g / 8] && wb_dat_i[g]) begin
          ovf_sts_q[g] <= 1'b0; // [R15]
        end
      end
    end
  endgenerate

  ecj_jit_peak u_jit (
    .clock(clock),
    .rst(rst),
    .smp(jit_smp),
    .round_end(jit_end),
    .pos_peak(pos_peak),
    .neg_peak(neg_peak)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      jit_cfg_q <= ecj_pkg::JIT_CFG_RESET;
    end else if (wr && idx == ecj_pkg::IDX_JIT_CFG) begin
      jit_cfg_q <= wb_dat_i[2:0]; // [R09] [R10] [R11] [R13]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stop_prev_q <= 1'b0;
    end else begin
      stop_prev_q <= jit_cfg_q[ecj_pkg::JIT_STOP_BIT]; // [R08]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_ctrl_q <= ecj_pkg::ERR_CTRL_RESET;
      err_trig_q <= 1'b0;
    end else begin
      err_trig_q <= wr && idx == ecj_pkg::IDX_ERR_CTRL &&
                    wb_dat_i[ecj_pkg::ERR_TRIG_BIT];
      if (wr && idx == ecj_pkg::IDX_ERR_CTRL) begin
        err_ctrl_q <= {wb_dat_i[ecj_pkg::ERR_MODE_BIT], 1'b0};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_mask_q <= ecj_pkg::MASK_RESET;
    end else if (req && wb_we_i && idx == ecj_pkg::IDX_OVF_MASK) begin
      if (wb_sel_i[0]) begin
        ovf_mask_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ovf_mask_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Band select and interrupt outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      band_q <= '0;
    end else begin
      band_q.e1_mode <= e1_mode; // [R16]
      band_q.wide_low_corner <= jit_cfg_q[ecj_pkg::JIT_BW_BIT]; // [R10] [R11]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ovf_sts_q & ovf_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_d = 32'h00000000;
    if (idx < ecj_pkg::IDX_CH_LIMIT &&
        idx[5:0] == ecj_pkg::IDX_ERR_LOW_CH1[5:0]) begin
      rd_d[7:0] = snap[4'(idx[9:6] + 4'h1)][7:0]; // [R01] [R02]
    end else if (idx < ecj_pkg::IDX_CH_LIMIT &&
                 idx[5:0] == ecj_pkg::IDX_ERR_HIGH_CH1[5:0]) begin
      rd_d[7:0] = snap[4'(idx[9:6] + 4'h1)][15:8]; // [R01] [R02]
    end else begin
      case (idx)
        ecj_pkg::IDX_ERR_LOW_CH0: rd_d[7:0] = snap[0][7:0]; // [R02]
        ecj_pkg::IDX_ERR_HIGH_CH0: rd_d[7:0] = snap[0][15:8];
        ecj_pkg::IDX_JIT_CFG: rd_d[2:0] = jit_cfg_q; // [R13]
        ecj_pkg::IDX_JIT_POS_LOW: rd_d[7:0] = pos_peak[7:0]; // [R12]
        ecj_pkg::IDX_JIT_POS_HIGH: rd_d[3:0] = pos_peak[11:8]; // [R12]
        ecj_pkg::IDX_JIT_NEG_LOW: rd_d[7:0] = neg_peak[7:0];
        ecj_pkg::IDX_JIT_NEG_HIGH: rd_d[3:0] = neg_peak[11:8];
        ecj_pkg::IDX_OVF_STATUS: rd_d[15:0] = ovf_sts_q;
        ecj_pkg::IDX_OVF_MASK: rd_d[15:0] = ovf_mask_q;
        ecj_pkg::IDX_ERR_CTRL: rd_d[1:0] = err_ctrl_q;
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone answer, one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rd_q <= (req && !wb_we_i) ? rd_d : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign irq = irq_q;
  assign jit_band = band_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_follows: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  chk_stop_auto: assert property ( // [R06]
    (!jit_manual && !tick_q) |=> $stable(pos_peak) && $stable(neg_peak))
    else $error("jitter round ended in automatic mode without tick");

  chk_stop_edge: assert property ( // [R07]
    (jit_manual && $rose(jit_cfg_q[ecj_pkg::JIT_STOP_BIT])) |->
      ##1 (pos_peak == $past(u_jit.pos_run_q)))
    else $error("stop edge did not load positive peak");

  chk_cfg_write: assert property ( // [R09]
    (wr && idx == ecj_pkg::IDX_JIT_CFG) |=> jit_cfg_q == $past(wb_dat_i[2:0]))
    else $error("jitter config write lost");

  chk_snap_hold: assert property ( // [R05]
    !err_end |=> snap[0] == $past(snap[0]))
    else $error("channel 0 snapshot changed without round end");

  chk_peak_hold: assert property ( // [R14]
    !jit_end |=> $stable(pos_peak) && $stable(neg_peak))
    else $error("jitter peak changed without round end");

  chk_ovf_sticky: assert property ( // [R15]
    (ovf_sts_q != 16'h0000 && !(req && wb_we_i)) |=>
      (ovf_sts_q & $past(ovf_sts_q)) == $past(ovf_sts_q))
    else $error("overflow status dropped without clear");

  chk_irq_level: assert property ( // [R15]
    |(ovf_sts_q & ovf_mask_q) |=> irq)
    else $error("interrupt missing for unmasked status");

  chk_band_sel: assert property ( // [R10] [R11]
    ##1 jit_band.wide_low_corner == $past(jit_cfg_q[ecj_pkg::JIT_BW_BIT]))
    else $error("band select does not follow bandwidth bit");

  chk_auto_round: assert property ( // [R04]
    (!err_ctrl_q[ecj_pkg::ERR_MODE_BIT] && tick_q) |=>
      snap[3] == $past(g_ch[3].u_chan.acc_q))
    else $error("automatic error round missed");

  chk_manual_round: assert property ( // [R04] [R05]
    (err_ctrl_q[ecj_pkg::ERR_MODE_BIT] && err_trig_q) |=>
      snap[1] == $past(g_ch[1].u_chan.acc_q))
    else $error("manual error round did not load snapshot");

  chk_ovf_set: assert property ( // [R15]
    (ovf_pulse != 16'h0000) |=>
      (ovf_sts_q & $past(ovf_pulse)) == $past(ovf_pulse))
    else $error("counter wrap did not set status");

  chk_ovf_clear: assert property ( // [R15]
    (req && wb_we_i && idx == ecj_pkg::IDX_OVF_STATUS &&
     wb_sel_i == 4'hF && ovf_pulse == 16'h0000) |=>
      (ovf_sts_q & $past(wb_dat_i[15:0])) == 16'h0000)
    else $error("status bit not cleared by writing one");

  chk_irq_quiet: assert property ( // [R15]
    !(|(ovf_sts_q & ovf_mask_q)) |=> !irq)
    else $error("interrupt without unmasked status");

  chk_ro_count: assert property ( // [R03]
    (req && wb_we_i && idx == ecj_pkg::IDX_ERR_LOW_CH1 && !err_end) |=>
      $stable(snap[1]))
    else $error("write changed a read-only snapshot");

  chk_rd_ch0: assert property ( // [R02]
    (req && !wb_we_i && idx == ecj_pkg::IDX_ERR_LOW_CH0) |=>
      wb_dat_o[7:0] == $past(snap[0][7:0]))
    else $error("channel 0 low byte read wrong");

  chk_rd_high: assert property ( // [R01]
    (req && !wb_we_i && idx == ecj_pkg::IDX_ERR_HIGH_CH1) |=>
      wb_dat_o[7:0] == $past(snap[1][15:8]))
    else $error("channel 1 high byte read wrong");

  chk_peak_high: assert property ( // [R12]
    (req && !wb_we_i && idx == ecj_pkg::IDX_JIT_POS_HIGH) |=>
      wb_dat_o == {28'h0000000, $past(pos_peak[11:8])})
    else $error("positive peak high nibble read wrong");

endmodule
`default_nettype wire

// >>> ecj_top_test.sv
// Self-checking bench for the error count and jitter readout block.
// Assumes one 100 MHz clock; drives Wishbone, error pulses and samples.
`timescale 1ns/100ps
`default_nettype none
module ecj_top_test;
  localparam int R = 50;
  logic clock;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic e1;
  logic [13:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [15:0] errp;
  ecj_pkg::ecj_jit_smp_t smp;
  ecj_pkg::ecj_band_t band;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] q;

  ecj_top #(.ROUND_CYCLES(R)) dut (
    .clock(clock),
    .rst(rst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .err_pulse(errp),
    .jit_smp(smp),
    .e1_mode(e1),
    .jit_band(band),
    .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; q holds the read byte
  task automatic xfer(input logic [11:0] idx, input logic wr,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic rd(input string name, input logic [11:0] idx,
                    input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    check(name, {8'h00, q}, {8'h00, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic hold_err(input logic [15:0] v, input int n);
    repeat (n) begin
      @(posedge clock);
      errp <= v;
    end
    @(posedge clock);
    errp <= 16'h0000;
  endtask

  task automatic send(input logic [11:0] p, input logic [11:0] n);
    @(posedge clock);
    smp <= {1'b1, p, n};
    @(posedge clock);
    smp <= '0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 14'h0000;
    sel = 4'h0;
    wdat = 32'h00000000;
    errp = 16'h0000;
    smp = '0;
    e1 = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd("err low ch1", 12'h023, 8'h00);
    rd("err high ch0", 12'h7E4, 8'h00);
    rd("jitter config", 12'h7E5, 8'h00);
    rd("pos peak low", 12'h7E6, 8'h00);
    rd("unmapped", 12'h100, 8'h00);
    xfer(12'h023, 1'b1, 8'h5A);
    rd("err low after write", 12'h023, 8'h00);
    $display("test reset done");

    e1 <= 1'b1;
    xfer(12'h7E5, 1'b1, 8'h01);
    tick(3);
    check("band wide", {15'h0000, band.wide_low_corner}, 16'h0001);
    check("band e1", {15'h0000, band.e1_mode}, 16'h0001);
    rd("jitter config", 12'h7E5, 8'h01);
    e1 <= 1'b0;
    xfer(12'h7E5, 1'b1, 8'h00);
    tick(3);
    check("band narrow", {15'h0000, band.wide_low_corner}, 16'h0000);
    check("band t1", {15'h0000, band.e1_mode}, 16'h0000);
    $display("test band done");

    xfer(12'h7F2, 1'b1, 8'h02);
    hold_err(16'h8003, 3);
    hold_err(16'h8002, 2);
    hold_err(16'h8000, 295);
    rd("err low before trigger", 12'h023, 8'h00);
    xfer(12'h7F2, 1'b1, 8'h03);
    tick(4);
    rd("err low ch1", 12'h023, 8'h05);
    rd("err high ch1", 12'h024, 8'h00);
    rd("err low ch0", 12'h7E3, 8'h03);
    rd("err ctrl", 12'h7F2, 8'h02);
    rd("err low ch15", 12'h3A3, 8'h2C);
    rd("err high ch15", 12'h3A4, 8'h01);
    hold_err(16'h0002, 1);
    xfer(12'h7F2, 1'b1, 8'h03);
    tick(4);
    rd("err low ch15 next", 12'h3A3, 8'h00);
    rd("err low ch1 next", 12'h023, 8'h01);
    $display("test manual count done");

    xfer(12'h7F1, 1'b1, 8'h04);
    hold_err(16'h0004, 65536);
    tick(4);
    rd("overflow status", 12'h7F0, 8'h04);
    check("irq raised", {15'h0000, irq}, 16'h0001);
    xfer(12'h7F1, 1'b1, 8'h00);
    tick(2);
    check("irq masked", {15'h0000, irq}, 16'h0000);
    xfer(12'h7F1, 1'b1, 8'h04);
    xfer(12'h7F0, 1'b1, 8'h04);
    tick(2);
    rd("overflow cleared", 12'h7F0, 8'h00);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    $display("test overflow done");

    send(12'h123, 12'h010);
    send(12'h7FF, 12'h020);
    send(12'h456, 12'h300);
    xfer(12'h7E5, 1'b1, 8'h04);
    tick(4);
    rd("pos low", 12'h7E6, 8'hFF);
    rd("pos high", 12'h7E7, 8'h07);
    rd("neg low", 12'h7E8, 8'h00);
    rd("neg high", 12'h7E9, 8'h03);
    xfer(12'h7E5, 1'b1, 8'h00);
    send(12'h015, 12'h001);
    tick(R + 5);
    rd("pos low held", 12'h7E6, 8'hFF);
    xfer(12'h7E5, 1'b1, 8'h04);
    tick(4);
    rd("pos low next", 12'h7E6, 8'h15);
    rd("pos high next", 12'h7E7, 8'h00);
    rd("neg low next", 12'h7E8, 8'h01);
    $display("test manual jitter done");

    xfer(12'h7F2, 1'b1, 8'h00);
    xfer(12'h7E5, 1'b1, 8'h02);
    @(posedge clock);
    errp <= 16'h0008;
    smp <= {1'b1, 12'h0AB, 12'h0CD};
    tick(2 * R + 4);
    xfer(12'h7E5, 1'b1, 8'h06);
    rd("err low ch3 auto", 12'h0A3, 8'h32);
    rd("err high ch3 auto", 12'h0A4, 8'h00);
    rd("pos low auto", 12'h7E6, 8'hAB);
    rd("neg low auto", 12'h7E8, 8'hCD);
    $display("test automatic rounds done");

    @(posedge clock);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    rd("err low ch3 reset", 12'h0A3, 8'h00);
    rd("pos low reset", 12'h7E6, 8'h00);
    rd("jitter config reset", 12'h7E5, 8'h00);
    check("irq reset", {15'h0000, irq}, 16'h0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
